// [inc/dts_pkg.sv]
package dts_pkg;
	// command codes
	localparam logic [7:0] DTS_CMD_TEMP_SLOPE = 8'hdc;
	localparam logic [7:0] DTS_CMD_GAP_TIME = 8'hdd;
	localparam logic [7:0] DTS_CMD_GAP_SETUP = 8'hde;
	localparam logic [7:0] DTS_CMD_RAIL_LINKS = 8'he0;
	localparam logic [7:0] DTS_CMD_FOLLOW = 8'he1;
	// values after reset
	localparam logic [7:0] DTS_RST_TEMP_SLOPE = 8'h00;
	localparam logic [15:0] DTS_RST_GAP_TIME = 16'h1018;
	localparam logic [15:0] DTS_RST_GAP_SETUP = 16'h8686;
	localparam logic [15:0] DTS_RST_RAIL_LINKS = 16'h0000;
	localparam logic [7:0] DTS_RST_FOLLOW = 8'h00;
	// writable bits; reserved bits read as zero
	localparam logic [15:0] DTS_MASK_RAIL_LINKS = 16'h9f9f;
	localparam logic [7:0] DTS_MASK_FOLLOW = 8'h87;
	// field positions
	localparam int DTS_TS_SRC_BIT = 7;
	localparam int DTS_TS_TC_MSB = 6;
	localparam int DTS_GS_HL_FREEZE = 15;
	localparam int DTS_GS_HL_MIN_LSB = 8;
	localparam int DTS_GS_LH_FREEZE = 7;
	localparam int DTS_GS_LH_MIN_LSB = 0;
	localparam int DTS_RL_PRE_EN = 15;
	localparam int DTS_RL_PRE_ID_LSB = 8;
	localparam int DTS_RL_SEQ_EN = 7;
	localparam int DTS_RL_SEQ_ID_LSB = 0;
	localparam int DTS_FM_TRACK_EN = 7;
	localparam int DTS_FM_HALF = 2;
	localparam int DTS_FM_CAP_REF = 1;
	localparam int DTS_FM_FALL_EARLY = 0;
	// arithmetic constants
	localparam logic signed [9:0] DTS_TEMP_REF_C = 10'sd25;
	localparam logic signed [35:0] DTS_TC_SCALE = 36'sd10000;
	localparam logic signed [9:0] DTS_MIN_STEP_NS = 10'sd2;
	localparam logic signed [9:0] DTS_GAP_LO_NS = -10'sd15;
	localparam logic signed [9:0] DTS_GAP_HI_NS = 10'sd60;
	localparam int DTS_SYNC_W = 19;
	typedef enum logic [1:0] {
		DTS_ST_OFF,
		DTS_ST_WAIT_PRE,
		DTS_ST_ON
	} dts_seq_state_t;
endpackage : dts_pkg

// [rtl/dts_cfg_bank.sv]
`timescale 1ns/1ps
// Summary of operation
// - temp_slope_setup bit 7 zero selects internal temperature sensor.
// - bits 6:0 slope factor, resistance = gain*(1+factor*(T-25)), 100 ppm steps.
// - slope correction applied negatively to the sensed current gain.
// - switch_gap_time upper byte high-to-low signed ns, lower byte low-to-high.
// - positive gap separates drive on-times, negative gap overlaps them.
// - frozen mode uses written gap, kept between minimum and ceiling.
// - adaptive-to-frozen write holds the last gap in effect.
// - switch_gap_time resets to 16 ns and 24 ns, range -15..60 ns.
// - setup bit 15: zero adaptive, one frozen, high-to-low.
// - setup bits 14:8 high-to-low minimum, 2 ns steps.
// - setup bit 7: zero adaptive, one frozen, low-to-high.
// - setup bits 6:0 low-to-high minimum, 2 ns steps.
// - switch_gap_setup resets with adaptive disabled both ways.
// - prequel enabled: turn on after enable state and prequel power-good event.
// - sequel enabled: turn off once sequel power-down event arrives.
// - links word: 15 prequel enable, 12:8 id, 7 sequel enable, 4:0 id.
// - a written links word overrides strap sequencing.
// - links word resets to zero, strap links stay in effect until it is written.
// - follow bit 7 enables tracking, byte resets to zero.
// - follow bit 2: zero tracks 100 percent, one tracks 50 percent.
// - follow bit 1: zero caps at target, one caps at reference.
// - follow bit 0: one lets output track reference down before power-good.
// - each rail has a 5-bit event identifier matched against link fields.
module dts_cfg_bank
	import dts_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	output logic [15:0] cmd_rdata,
	output logic cmd_ack,
	output logic cmd_nak,
	input wire logic [4:0] rail_event_identifier,
	input wire logic evt_pg_in,
	input wire logic evt_pd_in,
	input wire logic [4:0] evt_id_in,
	input wire logic strap_prequel_en,
	input wire logic [4:0] strap_prequel_id,
	input wire logic strap_sequel_en,
	input wire logic [4:0] strap_sequel_id,
	input wire logic enable_state,
	input wire logic power_good,
	input wire logic signed [7:0] temp_internal,
	input wire logic signed [7:0] temp_external,
	input wire logic [15:0] current_sense_gain,
	input wire logic signed [7:0] adapt_hl_ns,
	input wire logic signed [7:0] adapt_lh_ns,
	input wire logic signed [7:0] switch_gap_ceiling_hl,
	input wire logic signed [7:0] switch_gap_ceiling_lh,
	output logic temp_ext_sel,
	output logic [15:0] sense_element_resistance,
	output logic [15:0] corrected_sense_gain,
	output logic signed [7:0] gap_hl_ns,
	output logic signed [7:0] gap_lh_ns,
	output logic overlap_hl,
	output logic overlap_lh,
	output logic output_on,
	output logic turn_off_req,
	output logic tx_pg_evt,
	output logic tx_pd_evt,
	output logic [4:0] tx_rail_id,
	output logic track_en,
	output logic track_half_ratio,
	output logic track_cap_ref,
	output logic track_fall_early
);

	function automatic logic signed [9:0] clamp_gap(input logic signed [9:0] v, input logic signed [9:0] lo,
			input logic signed [9:0] hi);
		logic signed [9:0] r;
		r = v;
		if (r > hi) begin
			r = hi;
		end
		// the minimum wins over a ceiling set below it
		if (r < lo) begin
			r = lo;
		end
		if (r > DTS_GAP_HI_NS) begin
			r = DTS_GAP_HI_NS;
		end
		if (r < DTS_GAP_LO_NS) begin
			r = DTS_GAP_LO_NS;
		end
		return r;
	endfunction : clamp_gap

	function automatic logic [15:0] sat16(input logic signed [35:0] v);
		logic [15:0] r;
		r = v[15:0];
		if (v < 36'sd0) begin
			r = 16'h0000;
		end else if (v > 36'sd65535) begin
			r = 16'hffff;
		end
		return r;
	endfunction : sat16

	logic [7:0] temp_slope_setup;
	logic [15:0] switch_gap_time;
	logic [15:0] switch_gap_setup;
	logic [15:0] rail_order_links;
	logic [7:0] follow_mode_setup;
	logic links_written;

	// command decode
	wire hit_ts = cmd_code == DTS_CMD_TEMP_SLOPE;
	wire hit_gt = cmd_code == DTS_CMD_GAP_TIME;
	wire hit_gs = cmd_code == DTS_CMD_GAP_SETUP;
	wire hit_rl = cmd_code == DTS_CMD_RAIL_LINKS;
	wire hit_fm = cmd_code == DTS_CMD_FOLLOW;
	wire cmd_hit = hit_ts | hit_gt | hit_gs | hit_rl | hit_fm;
	wire wr_ts = cmd_wr & hit_ts;
	wire wr_gt = cmd_wr & hit_gt;
	wire wr_gs = cmd_wr & hit_gs;
	wire wr_rl = cmd_wr & hit_rl;
	wire wr_fm = cmd_wr & hit_fm;
	wire [15:0] rd_mux = hit_ts ? {8'h00, temp_slope_setup} :
		hit_gt ? switch_gap_time :
		hit_gs ? switch_gap_setup :
		hit_rl ? rail_order_links :
		hit_fm ? {8'h00, follow_mode_setup} : 16'h0000;

	// pin inputs: three stages, a bit changes once stages two and three agree
	wire [DTS_SYNC_W-1:0] pin_raw = {evt_pg_in, evt_pd_in, evt_id_in, strap_prequel_en, strap_prequel_id,
		strap_sequel_en, strap_sequel_id};
	wire [DTS_SYNC_W-1:0] pin_filt;
	genvar gi;
	generate
		for (gi = 0; gi < DTS_SYNC_W; gi++) begin : g_sync
			logic s1, s2, s3, sf;
			always_ff @(posedge sys_clk) begin
				if (!resetn) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
					sf <= 1'b0;
				end else begin
					s1 <= pin_raw[gi];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3) begin
						sf <= s3;
					end
				end
			end
			assign pin_filt[gi] = sf;
		end
	endgenerate

	wire f_pg = pin_filt[18];
	wire f_pd = pin_filt[17];
	wire [4:0] f_evt_id = pin_filt[16:12];
	logic f_pg_d, f_pd_d;
	wire rx_pg = f_pg & ~f_pg_d;
	wire rx_pd = f_pd & ~f_pd_d;

	// effective links: strap until software writes the links word
	// strap enables are pins too, so only their filtered copies are used
	wire [15:0] strap_links = {pin_filt[11], 2'b00, pin_filt[10:6], pin_filt[5], 2'b00, pin_filt[4:0]};
	wire [15:0] eff_links = links_written ? rail_order_links : strap_links;
	wire pre_en = eff_links[DTS_RL_PRE_EN];
	wire [4:0] pre_id = eff_links[DTS_RL_PRE_ID_LSB +: 5];
	wire seq_en = eff_links[DTS_RL_SEQ_EN];
	wire [4:0] seq_id = eff_links[DTS_RL_SEQ_ID_LSB +: 5];
	wire pre_pg_hit = rx_pg & (f_evt_id == pre_id);
	wire pre_pd_hit = rx_pd & (f_evt_id == pre_id);
	wire seq_pd_hit = rx_pd & (f_evt_id == seq_id);
	wire seq_pg_hit = rx_pg & (f_evt_id == seq_id);
	logic prequel_good, sequel_down;

	// dead time selection
	wire hl_frozen = switch_gap_setup[DTS_GS_HL_FREEZE];
	wire lh_frozen = switch_gap_setup[DTS_GS_LH_FREEZE];
	wire signed [9:0] hl_min = DTS_MIN_STEP_NS * $signed({3'b000, switch_gap_setup[DTS_GS_HL_MIN_LSB +: 7]});
	wire signed [9:0] lh_min = DTS_MIN_STEP_NS * $signed({3'b000, switch_gap_setup[DTS_GS_LH_MIN_LSB +: 7]});
	wire signed [9:0] hl_src = hl_frozen ? 10'(signed'(switch_gap_time[15:8])) : 10'(adapt_hl_ns);
	wire signed [9:0] lh_src = lh_frozen ? 10'(signed'(switch_gap_time[7:0])) : 10'(adapt_lh_ns);
	wire signed [9:0] next_gap_hl = clamp_gap(hl_src, hl_min, 10'(switch_gap_ceiling_hl));
	wire signed [9:0] next_gap_lh = clamp_gap(lh_src, lh_min, 10'(switch_gap_ceiling_lh));
	// adaptive to frozen on this write: the live gap is captured into the time word
	wire hl_freeze_now = wr_gs & cmd_wdata[DTS_GS_HL_FREEZE] & ~hl_frozen;
	wire lh_freeze_now = wr_gs & cmd_wdata[DTS_GS_LH_FREEZE] & ~lh_frozen;

	// temperature correction
	wire signed [7:0] temp_sel = temp_slope_setup[DTS_TS_SRC_BIT] ? temp_external : temp_internal;
	wire signed [9:0] temp_delta = 10'(temp_sel) - DTS_TEMP_REF_C;
	wire signed [35:0] slope_prod = $signed({20'h00000, current_sense_gain}) *
		$signed({29'h0, temp_slope_setup[DTS_TS_TC_MSB:0]}) * 36'(temp_delta);
	wire signed [35:0] slope_delta = slope_prod / DTS_TC_SCALE;
	wire signed [35:0] gain_wide = $signed({20'h00000, current_sense_gain});

	dts_seq_state_t seq_state, next_seq_state;
	// a powered-down sequel keeps this rail off, otherwise it would turn on and off again
	wire want_on = enable_state & (~pre_en | prequel_good) & ~(seq_en & sequel_down);
	wire must_off = ~enable_state | (seq_en & sequel_down);
	always_comb begin
		next_seq_state = seq_state;
		case (seq_state)
			DTS_ST_OFF: begin
				if (enable_state) begin
					next_seq_state = DTS_ST_WAIT_PRE;
				end
			end
			DTS_ST_WAIT_PRE: begin
				if (!enable_state) begin
					next_seq_state = DTS_ST_OFF;
				end else if (want_on) begin
					next_seq_state = DTS_ST_ON;
				end
			end
			DTS_ST_ON: begin
				if (must_off) begin
					next_seq_state = DTS_ST_OFF;
				end
			end
			default: next_seq_state = DTS_ST_OFF;
		endcase
	end

	// register file
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			temp_slope_setup <= DTS_RST_TEMP_SLOPE;
			switch_gap_time <= DTS_RST_GAP_TIME;
			switch_gap_setup <= DTS_RST_GAP_SETUP;
			rail_order_links <= DTS_RST_RAIL_LINKS;
			follow_mode_setup <= DTS_RST_FOLLOW;
			links_written <= 1'b0;
		end else begin
			if (wr_ts) begin
				temp_slope_setup <= cmd_wdata[7:0];
			end
			if (wr_gt) begin
				switch_gap_time <= cmd_wdata;
			end else begin
				if (hl_freeze_now) begin
					switch_gap_time[15:8] <= gap_hl_ns;
				end
				if (lh_freeze_now) begin
					switch_gap_time[7:0] <= gap_lh_ns;
				end
			end
			if (wr_gs) begin
				switch_gap_setup <= cmd_wdata;
			end
			if (wr_rl) begin
				rail_order_links <= cmd_wdata & DTS_MASK_RAIL_LINKS;
				links_written <= 1'b1;
			end
			if (wr_fm) begin
				follow_mode_setup <= cmd_wdata[7:0] & DTS_MASK_FOLLOW;
			end
		end
	end

	// command answer, one cycle after the request
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cmd_rdata <= 16'h0000;
			cmd_ack <= 1'b0;
			cmd_nak <= 1'b0;
		end else begin
			cmd_ack <= (cmd_wr | cmd_rd) & cmd_hit;
			cmd_nak <= (cmd_wr | cmd_rd) & ~cmd_hit;
			if (cmd_rd) begin
				cmd_rdata <= rd_mux;
			end
		end
	end

	// event tracking; a new event beats the clearing one
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			f_pg_d <= 1'b0;
			f_pd_d <= 1'b0;
			prequel_good <= 1'b0;
			sequel_down <= 1'b0;
		end else begin
			f_pg_d <= f_pg;
			f_pd_d <= f_pd;
			if (pre_pg_hit) begin
				prequel_good <= 1'b1;
			end else if (pre_pd_hit | wr_rl) begin
				// a rewritten links word forgets what the old partners reported
				prequel_good <= 1'b0;
			end
			if (seq_pd_hit) begin
				sequel_down <= 1'b1;
			end else if (seq_pg_hit | wr_rl) begin
				sequel_down <= 1'b0;
			end
		end
	end

	logic pg_d;
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			seq_state <= DTS_ST_OFF;
			output_on <= 1'b0;
			turn_off_req <= 1'b0;
			tx_pg_evt <= 1'b0;
			tx_pd_evt <= 1'b0;
			tx_rail_id <= 5'h00;
			pg_d <= 1'b0;
		end else begin
			seq_state <= next_seq_state;
			output_on <= next_seq_state == DTS_ST_ON;
			// the shutdown delays live in the ramp logic downstream
			turn_off_req <= (seq_state == DTS_ST_ON) & must_off;
			pg_d <= power_good;
			tx_pg_evt <= power_good & ~pg_d;
			tx_pd_evt <= (seq_state == DTS_ST_ON) & must_off;
			tx_rail_id <= rail_event_identifier;
		end
	end

	// datapath outputs
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			gap_hl_ns <= 8'sh00;
			gap_lh_ns <= 8'sh00;
			overlap_hl <= 1'b0;
			overlap_lh <= 1'b0;
			temp_ext_sel <= 1'b0;
			sense_element_resistance <= 16'h0000;
			corrected_sense_gain <= 16'h0000;
			track_en <= 1'b0;
			track_half_ratio <= 1'b0;
			track_cap_ref <= 1'b0;
			track_fall_early <= 1'b0;
		end else begin
			gap_hl_ns <= next_gap_hl[7:0];
			gap_lh_ns <= next_gap_lh[7:0];
			overlap_hl <= next_gap_hl < 10'sd0;
			overlap_lh <= next_gap_lh < 10'sd0;
			temp_ext_sel <= temp_slope_setup[DTS_TS_SRC_BIT];
			sense_element_resistance <= sat16(gain_wide + slope_delta);
			corrected_sense_gain <= sat16(gain_wide - slope_delta);
			track_en <= follow_mode_setup[DTS_FM_TRACK_EN];
			track_half_ratio <= follow_mode_setup[DTS_FM_HALF];
			track_cap_ref <= follow_mode_setup[DTS_FM_CAP_REF];
			track_fall_early <= follow_mode_setup[DTS_FM_FALL_EARLY];
		end
	end

	default clocking dts_cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	a_gap_setup_reset: assert property ($rose(resetn) |-> switch_gap_setup == 16'h8686)
		else $error("gap setup reset value wrong");
	a_gap_time_reset: assert property ($rose(resetn) |-> switch_gap_time == 16'h1018)
		else $error("gap time reset value wrong");
	a_links_reset: assert property ($rose(resetn) |-> rail_order_links == 16'h0000 && !links_written)
		else $error("links reset value wrong");
	a_links_reserved: assert property (wr_rl |=> (rail_order_links & 16'h6060) == 16'h0000)
		else $error("links reserved bits not zero");
	a_gap_bounds: assert property (gap_hl_ns >= -8'sd15 && gap_hl_ns <= 8'sd60)
		else $error("high-to-low gap out of range");
	a_overlap_sign: assert property (overlap_lh == (gap_lh_ns < 8'sd0))
		else $error("overlap flag disagrees with gap sign");
	a_freeze_hold: assert property (hl_freeze_now && !wr_gt |=> switch_gap_time[15:8] == $past(gap_hl_ns))
		else $error("frozen gap not captured");
	a_prequel_wait: assert property (pre_en && !prequel_good && seq_state == DTS_ST_WAIT_PRE |=> !output_on)
		else $error("output on before prequel power-good");
	a_sequel_off: assert property (seq_state == DTS_ST_ON && seq_en && sequel_down |=> turn_off_req ##1 !output_on)
		else $error("sequel power-down did not turn off");
	a_strap_override: assert property (links_written |-> eff_links == rail_order_links)
		else $error("strap overrides written links");
	a_track_ratio: assert property (wr_fm |=> ##1 track_half_ratio == follow_mode_setup[2])
		else $error("tracking ratio not applied");
	a_temp_source: assert property (wr_ts |=> ##1 temp_ext_sel == $past(cmd_wdata[7], 2))
		else $error("temperature source not applied");

	c_turn_on: cover property (seq_state == DTS_ST_WAIT_PRE ##1 output_on);
	c_sequel_down: cover property (seq_pd_hit ##[1:4] turn_off_req);
	c_freeze: cover property (hl_freeze_now);
	c_overlap: cover property (overlap_hl);
endmodule : dts_cfg_bank

// [tb/dts_peer_rail.sv]
`timescale 1ns/1ps
// model of a peer rail on the intermodule event bus
module dts_peer_rail (
	input wire logic sys_clk,
	output logic evt_pg_in,
	output logic evt_pd_in,
	output logic [4:0] evt_id_in
);
	initial begin
		evt_pg_in = 1'b0;
		evt_pd_in = 1'b0;
		evt_id_in = 5'h1f;
	end
	// id is set up well before the edge so the receiver's filter sees it settled
	task automatic send(input logic pd, input logic [4:0] id);
		@(posedge sys_clk);
		#1;
		evt_id_in = id;
		repeat (4) @(posedge sys_clk);
		#1;
		if (pd) evt_pd_in = 1'b1;
		else evt_pg_in = 1'b1;
		repeat (6) @(posedge sys_clk);
		#1;
		evt_pg_in = 1'b0;
		evt_pd_in = 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		// released id line carries no meaning, so show garbage
		evt_id_in = ~id;
	endtask : send
endmodule : dts_peer_rail

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import dts_pkg::*;
	logic sys_clk = 0, resetn = 0, cmd_wr = 0, cmd_rd = 0, cmd_ack, cmd_nak;
	logic [7:0] cmd_code = 8'h00;
	logic [15:0] cmd_wdata = 16'h0000, cmd_rdata, q, d, gain = 16'h2710, ser, csg;
	logic [1:0] an;
	logic en = 0, pgood = 0, sp_en = 0, sq_en = 0, evt_pg_in, evt_pd_in, temp_ext_sel, overlap_hl, overlap_lh;
	logic output_on, turn_off_req, tx_pg_evt, tx_pd_evt, track_en, track_half_ratio, track_cap_ref, track_fall_early;
	logic [4:0] evt_id_in, tx_rail_id, sp_id = 5'h03, sq_id = 5'h00, my_id = 5'h09;
	logic signed [7:0] t_in = 8'sd45, t_ex = 8'sd5, a_hl = 8'sd0, a_lh = 8'sd0, c_hl = 8'sd60, c_lh = 8'sd60;
	logic signed [7:0] gap_hl_ns, gap_lh_ns;
	int err_count = 0, comparisons = 0, seed = 85006, i, j, k, e, off_pulses = 0, pd_pulses = 0;
	logic [7:0] codes [5] = '{DTS_CMD_TEMP_SLOPE, DTS_CMD_GAP_TIME, DTS_CMD_GAP_SETUP, DTS_CMD_RAIL_LINKS, DTS_CMD_FOLLOW};
	logic [15:0] masks [5] = '{16'h00ff, 16'hffff, 16'hffff, DTS_MASK_RAIL_LINKS, {8'h00, DTS_MASK_FOLLOW}};
	logic [15:0] rv [5] = '{16'h0000, DTS_RST_GAP_TIME, DTS_RST_GAP_SETUP, DTS_RST_RAIL_LINKS, 16'h0000};

	always #2.5 sys_clk = ~sys_clk;

	// one-cycle pulses are counted away from the edge that launches them
	always @(negedge sys_clk) begin
		if (turn_off_req === 1'b1) off_pulses++;
		if (tx_pd_evt === 1'b1) pd_pulses++;
	end

	dts_cfg_bank DUT (.sys_clk, .resetn, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .cmd_rdata, .cmd_ack, .cmd_nak,
		.rail_event_identifier(my_id), .evt_pg_in, .evt_pd_in, .evt_id_in, .strap_prequel_en(sp_en),
		.strap_prequel_id(sp_id), .strap_sequel_en(sq_en), .strap_sequel_id(sq_id), .enable_state(en),
		.power_good(pgood), .temp_internal(t_in), .temp_external(t_ex), .current_sense_gain(gain),
		.adapt_hl_ns(a_hl), .adapt_lh_ns(a_lh), .switch_gap_ceiling_hl(c_hl), .switch_gap_ceiling_lh(c_lh),
		.temp_ext_sel, .sense_element_resistance(ser), .corrected_sense_gain(csg), .gap_hl_ns, .gap_lh_ns,
		.overlap_hl, .overlap_lh, .output_on, .turn_off_req, .tx_pg_evt, .tx_pd_evt, .tx_rail_id, .track_en,
		.track_half_ratio, .track_cap_ref, .track_fall_early);
	dts_peer_rail peer (.sys_clk, .evt_pg_in, .evt_pd_in, .evt_id_in);

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step

	task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] dat);
		step(1);
		cmd_wr = wr;
		cmd_rd = !wr;
		cmd_code = code;
		cmd_wdata = dat;
		step(1);
		q = cmd_rdata;
		an = {cmd_ack, cmd_nak};
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
	endtask : access

	task automatic wr(input int r, input logic [15:0] dat);
		access(1'b1, codes[r], dat);
		check(16'(an), 16'h0002, "write ack");
		rv[r] = dat & masks[r];
	endtask : wr

	task automatic rd_all;
		for (int r = 0; r < 5; r++) begin
			access(1'b0, codes[r], 16'h0000);
			check(16'(an), 16'h0002, "read ack");
			check(q, rv[r], "readback");
		end
	endtask : rd_all

	// bounded wait on the output enable level
	task automatic wait_on(input logic v, input int n);
		k = 0;
		while (output_on !== v && k < n) begin
			step(1);
			k++;
		end
		check(16'(output_on), 16'(v), "output_on");
		if (output_on !== v) final_report();
	endtask : wait_on

	// ceiling first, then the minimum wins, then the overall range
	function automatic int clampg(input int v, input int mn, input int cl);
		if (v > cl) v = cl;
		if (v < mn * 2) v = mn * 2;
		if (v < -15) v = -15;
		if (v > 60) v = 60;
		return v;
	endfunction : clampg

	// sense terms: gain plus or minus gain*tc*(t-25)/10000, saturated to 16 bits
	function automatic logic [15:0] sense_exp(input int g, input int tc, input int t, input int sgn);
		int v;
		v = g + sgn * ((g * tc * (t - 25)) / 10000);
		if (v < 0) v = 0;
		if (v > 65535) v = 65535;
		return 16'(v);
	endfunction : sense_exp

	task automatic check_gaps;
		e = clampg($signed(rv[1][15:8]), rv[2][14:8], c_hl);
		check(16'(gap_hl_ns), 16'(e), "gap hl");
		check(16'(overlap_hl), 16'(e < 0), "overlap hl");
		e = clampg($signed(rv[1][7:0]), rv[2][6:0], c_lh);
		check(16'(gap_lh_ns), 16'(e), "gap lh");
		check(16'(overlap_lh), 16'(e < 0), "overlap lh");
	endtask : check_gaps

	initial begin
		step(30000);
		err_count++;
		final_report();
	end

	initial begin
		step(12);
		resetn = 1'b1;
		rd_all();
		access(1'b0, 8'hdf, 16'h0000);
		check(16'(an), 16'h0001, "unmapped nak");
		check(q, 16'h0000, "unmapped data");
		check_gaps();
		$display("test reset done");

		sp_en = 1'b1;
		// the strap enable has to pass the pin filter before the rail is enabled
		step(8);
		en = 1'b1;
		step(20);
		check(16'(output_on), 16'h0000, "waits for prequel");
		peer.send(1'b0, 5'h04);
		step(10);
		check(16'(output_on), 16'h0000, "foreign id ignored");
		peer.send(1'b0, 5'h03);
		wait_on(1'b1, 20);
		pgood = 1'b1;
		check(16'(tx_rail_id), 16'(my_id), "own id");
		step(1);
		check(16'(tx_pg_evt), 16'h0001, "power good event");
		wr(3, 16'hff87);
		en = 1'b0;
		wait_on(1'b0, 10);
		en = 1'b1;
		step(20);
		check(16'(output_on), 16'h0000, "links override strap");
		peer.send(1'b0, 5'h1f);
		wait_on(1'b1, 20);
		off_pulses = 0;
		pd_pulses = 0;
		peer.send(1'b1, 5'h07);
		wait_on(1'b0, 20);
		step(10);
		check(16'(output_on), 16'h0000, "stays off after sequel down");
		check(16'(off_pulses), 16'h0001, "turn off pulse");
		check(16'(pd_pulses), 16'h0001, "power down event");
		$display("test sequencing done");

		for (i = 0; i < 40; i++) begin
			j = $unsigned($random(seed)) % 5;
			d = 16'($random(seed));
			c_hl = 8'(($unsigned($random(seed)) % 76) - 15);
			c_lh = 8'(($unsigned($random(seed)) % 76) - 15);
			if (j == 1) d = {8'(($unsigned($random(seed)) % 76) - 15), 8'(($unsigned($random(seed)) % 76) - 15)};
			if (j == 2) d = (d & 16'h8f8f) | 16'h8080;
			wr(j, d);
			rd_all();
			check_gaps();
			e = rv[0][7] ? t_ex : t_in;
			check(ser, sense_exp(gain, rv[0][6:0], e, 1), "resistance");
			check(csg, sense_exp(gain, rv[0][6:0], e, -1), "corrected");
			check({11'h000, temp_ext_sel, track_en, track_half_ratio, track_cap_ref, track_fall_early},
				{11'h000, rv[0][7], rv[4][7], rv[4][2:0]}, "mode bits");
		end
		$display("test random done");

		wr(0, 16'h0027);
		step(3);
		check(ser, sense_exp(gain, 8'h27, t_in, 1), "resistance internal");
		check(csg, sense_exp(gain, 8'h27, t_in, -1), "corrected internal");
		wr(0, 16'h00a7);
		step(3);
		check(ser, sense_exp(gain, 8'h27, t_ex, 1), "resistance external");
		check(csg, sense_exp(gain, 8'h27, t_ex, -1), "corrected external");
		$display("test temperature done");

		c_hl = 8'sd60;
		c_lh = 8'sd60;
		a_hl = 8'sd20;
		a_lh = -8'sd10;
		wr(2, 16'h0000);
		step(3);
		check(16'(gap_hl_ns), 16'h0014, "adaptive hl");
		check(16'(gap_lh_ns), 16'h0000, "adaptive lh floor");
		check(16'(overlap_lh), 16'h0000, "adaptive lh no overlap");
		wr(2, 16'h0505);
		step(3);
		check(16'(gap_lh_ns), 16'h000a, "adaptive lh minimum");
		wr(2, 16'h8505);
		a_hl = 8'sd40;
		step(3);
		check(16'(gap_hl_ns), 16'h0014, "frozen holds");
		rv[1][15:8] = 8'h14;
		rd_all();
		$display("test adaptive done");
		final_report();
	end
endmodule : tb_top
